/* File: sbd_pkg.sv */
// Constants and encodings for the subtract instruction datapath.
// Assumes a 16-bit instruction word delivered by the decoder, one per instruction cycle.
// Function
// - Literal-subtract: literal minus working register, result always to working register.
// - File-subtract: addressed file register minus working register, six-bit prefix decoded.
// - Destination bit zero stores to working register, one stores to file register.
// - Bank bit zero uses access bank; one combines address with bank select register.
// - Bank zero, extended set on, address at most 95: indexed literal offset addressing.
// - Carry set when no borrow (result non-negative), cleared on borrow.
// - Subtract-with-borrow: working minus file minus inverted carry, same operand handling.
package sbd_pkg;
    localparam logic [7:0]  LIT_SUB_CODE   = 8'h08;   // Upper byte of literal subtract
    localparam logic [5:0]  FSUBW_CODE     = 6'h17;   // Prefix of file-minus-working
    localparam logic [5:0]  FSUBB_CODE     = 6'h15;   // Prefix of subtract with borrow
    localparam logic [7:0]  INDEX_MAX_ADDR = 8'h5F;   // Highest indexed offset address
    localparam logic [7:0]  ACCESS_SPLIT   = 8'h80;   // Access bank: low half bank 0, high half SFR
    localparam logic [3:0]  SFR_BANK       = 4'hF;    // Bank of upper access half
    localparam logic [3:0]  ZERO_BANK      = 4'h0;
    localparam int          DEST_BIT       = 9;
    localparam int          BANK_BIT       = 8;

    typedef enum logic [1:0] {
        SBD_DECODE  = 2'b00,
        SBD_READ    = 2'b01,
        SBD_PROCESS = 2'b10,
        SBD_WRITE   = 2'b11
    } sbd_phase_t;
endpackage : sbd_pkg

/* File: sbd_alu.sv */
// Eight-bit subtracter with full flag generation.
// Assumes operands are stable while results are registered by the caller.
module sbd_alu
    import sbd_pkg::*;
(
    input  wire logic [7:0] min_i,
    input  wire logic [7:0] sub_i,
    input  wire logic       borrow_in_i,
    output logic      [7:0] diff_o,
    output logic            carry_o,
    output logic            dcarry_o,
    output logic            ovf_o,
    output logic            neg_o,
    output logic            zero_o
);
    logic [8:0] full;
    logic [4:0] low;

    // Two's complement: a + ~b + carry, carry of one meaning no borrow
    always_comb begin
        full     = {1'b0, min_i} + {1'b0, ~sub_i} + {8'h00, ~borrow_in_i};
        low      = {1'b0, min_i[3:0]} + {1'b0, ~sub_i[3:0]} + {4'h0, ~borrow_in_i};
        diff_o   = full[7:0];
        carry_o  = full[8];
        dcarry_o = low[4];
        ovf_o    = (min_i[7] != sub_i[7]) && (full[7] != min_i[7]);
        neg_o    = full[7];
        zero_o   = (full[7:0] == 8'h00);
    end
endmodule : sbd_alu

/* File: sbd_core.sv */
// Subtract instruction datapath: decode, operand read, process, write phases.
// Assumes one instruction word held for a whole four-phase cycle by the decoder,
// and a register file whose read data is valid in the same clock as the address.
module sbd_core
    import sbd_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic        instr_valid_i,   // Start a new instruction cycle
    input  wire logic [15:0] instr_i,
    input  wire logic        carry_i,         // Current carry flag
    input  wire logic [7:0]  work_i,          // Current working register
    input  wire logic [3:0]  bank_select_register_i,
    input  wire logic        ext_set_i,       // Extended instruction set enabled
    input  wire logic [11:0] index_base_i,    // Index pointer for literal offset mode
    input  wire logic [7:0]  file_rdata_i,
    output logic      [11:0] file_addr_o,
    output logic             file_rd_o,
    output logic      [7:0]  file_wdata_o,
    output logic             file_wr_o,
    output logic      [7:0]  work_o,
    output logic             work_wr_o,
    output logic      [4:0]  flags_o,         // {neg, ovf, zero, digit_carry, carry}
    output logic             flags_wr_o,
    output logic             busy_o,
    output logic             done_o
);
    sbd_phase_t  phase_r, phase_nxt;
    logic        active_r, active_nxt;
    logic [1:0]  kind_r, kind_nxt;  // 0 none, 1 literal, 2 file-minus-w, 3 with borrow
    logic [15:0] op_r, op_nxt;
    logic [7:0]  opnd_r, opnd_nxt;
    logic [11:0] addr_r, addr_nxt;
    logic [7:0]  res_r, res_nxt;
    logic [4:0]  flg_r, flg_nxt;
    logic [11:0] faddr_r, faddr_nxt;
    logic        frd_r, frd_nxt, fwr_r, fwr_nxt, wwr_r, wwr_nxt, flw_r, flw_nxt, done_r, done_nxt;
    logic [7:0]  wout_r, wout_nxt, fwd_r, fwd_nxt;
    logic [7:0]  a_in, b_in, diff;
    logic        bin, c_o, dc_o, ov_o, n_o, z_o;
    logic [11:0] eff_addr;

    // Operand address resolution
    always_comb begin
        if (op_r[BANK_BIT]) begin
            eff_addr = {bank_select_register_i, op_r[7:0]};
        end else if (ext_set_i && (op_r[7:0] <= INDEX_MAX_ADDR)) begin
            eff_addr = index_base_i + {4'h0, op_r[7:0]};
        end else if (op_r[7:0] >= ACCESS_SPLIT) begin
            eff_addr = {SFR_BANK, op_r[7:0]};
        end else begin
            eff_addr = {ZERO_BANK, op_r[7:0]};
        end
    end

    // Operand steering per instruction kind
    always_comb begin
        a_in = opnd_r;
        b_in = work_i;
        bin  = 1'b0;
        if (kind_r == 2'd1) begin
            a_in = op_r[7:0];
        end else if (kind_r == 2'd3) begin
            a_in = work_i;
            b_in = opnd_r;
            bin  = ~carry_i;
        end
    end

    sbd_alu u_alu (
        .min_i       (a_in),
        .sub_i       (b_in),
        .borrow_in_i (bin),
        .diff_o      (diff),
        .carry_o     (c_o),
        .dcarry_o    (dc_o),
        .ovf_o       (ov_o),
        .neg_o       (n_o),
        .zero_o      (z_o)
    );

    // Phase sequencer and next-state computation
    always_comb begin
        phase_nxt  = phase_r;
        active_nxt = active_r;
        kind_nxt   = kind_r;
        op_nxt     = op_r;
        opnd_nxt   = opnd_r;
        addr_nxt   = addr_r;
        res_nxt    = res_r;
        flg_nxt    = flg_r;
        faddr_nxt  = faddr_r;
        frd_nxt    = 1'b0;
        fwr_nxt    = 1'b0;
        wwr_nxt    = 1'b0;
        flw_nxt    = 1'b0;
        done_nxt   = 1'b0;
        wout_nxt   = wout_r;
        fwd_nxt    = fwd_r;
        case (phase_r)
            SBD_DECODE: begin
                if (instr_valid_i) begin
                    op_nxt     = instr_i;
                    active_nxt = 1'b1;
                    phase_nxt  = SBD_READ;
                    if (instr_i[15:8] == LIT_SUB_CODE) begin
                        kind_nxt = 2'd1;
                    end else if (instr_i[15:10] == FSUBW_CODE) begin
                        kind_nxt = 2'd2;
                    end else if (instr_i[15:10] == FSUBB_CODE) begin
                        kind_nxt = 2'd3;
                    end else begin
                        kind_nxt = 2'd0;
                    end
                end
            end
            SBD_READ: begin
                addr_nxt  = eff_addr;
                faddr_nxt = eff_addr;
                frd_nxt   = (kind_r == 2'd2) || (kind_r == 2'd3);
                phase_nxt = SBD_PROCESS;
            end
            SBD_PROCESS: begin
                if (frd_r) begin
                    opnd_nxt = file_rdata_i;
                end
                phase_nxt = SBD_WRITE;
            end
            SBD_WRITE: begin
                // Result and flags move only for a recognised subtract
                if (kind_r != 2'd0) begin
                    res_nxt = diff;
                    flg_nxt = {n_o, ov_o, z_o, dc_o, c_o};
                    flw_nxt = 1'b1;
                    if ((kind_r == 2'd1) || !op_r[DEST_BIT]) begin
                        wout_nxt = diff;
                        wwr_nxt  = 1'b1;
                    end else begin
                        fwd_nxt   = diff;
                        faddr_nxt = addr_r;
                        fwr_nxt   = 1'b1;
                    end
                end
                done_nxt   = 1'b1;
                active_nxt = 1'b0;
                phase_nxt  = SBD_DECODE;
            end
            default: begin
                phase_nxt = SBD_DECODE;
            end
        endcase
    end

    // Register all state
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            phase_r  <= SBD_DECODE;
            active_r <= 1'b0;
            kind_r   <= 2'd0;
            op_r     <= 16'h0000;
            opnd_r   <= 8'h00;
            addr_r   <= 12'h000;
            res_r    <= 8'h00;
            flg_r    <= 5'h00;
            faddr_r  <= 12'h000;
            frd_r    <= 1'b0;
            fwr_r    <= 1'b0;
            wwr_r    <= 1'b0;
            flw_r    <= 1'b0;
            done_r   <= 1'b0;
            wout_r   <= 8'h00;
            fwd_r    <= 8'h00;
        end else begin
            phase_r  <= phase_nxt;
            active_r <= active_nxt;
            kind_r   <= kind_nxt;
            op_r     <= op_nxt;
            opnd_r   <= opnd_nxt;
            addr_r   <= addr_nxt;
            res_r    <= res_nxt;
            flg_r    <= flg_nxt;
            faddr_r  <= faddr_nxt;
            frd_r    <= frd_nxt;
            fwr_r    <= fwr_nxt;
            wwr_r    <= wwr_nxt;
            flw_r    <= flw_nxt;
            done_r   <= done_nxt;
            wout_r   <= wout_nxt;
            fwd_r    <= fwd_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign file_addr_o  = faddr_r;
    assign file_rd_o    = frd_r;
    assign file_wdata_o = fwd_r;
    assign file_wr_o    = fwr_r;
    assign work_o       = wout_r;
    assign work_wr_o    = wwr_r;
    assign flags_o      = flg_r;
    assign flags_wr_o   = flw_r;
    assign busy_o       = active_r;
    assign done_o       = done_r;

    // Exactly one destination per completed subtract
    one_dest_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        flags_wr_o |-> (file_wr_o ^ work_wr_o)) else $error("no unique destination");
    // Literal subtract always targets working register
    lit_dest_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (flags_wr_o && kind_r == 2'd1) |-> work_wr_o) else $error("literal not to W");
    // Zero flag matches the stored result
    zero_flag_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        flags_wr_o |-> (flags_o[2] == (res_r == 8'h00))) else $error("zero flag wrong");
    // Negative flag mirrors result sign
    neg_flag_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        flags_wr_o |-> (flags_o[4] == res_r[7])) else $error("neg flag wrong");
    // File write data equals result
    file_data_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        file_wr_o |-> (file_wdata_o == res_r)) else $error("file data wrong");
    // Banked address uses bank select register
    bank_addr_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (phase_r == SBD_READ && op_r[BANK_BIT])
        |=> ((addr_r[11:8] == $past(bank_select_register_i)) && (addr_r[7:0] == op_r[7:0])))
        else $error("bank address wrong");
    // Indexed mode offsets from index base
    index_addr_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (phase_r == SBD_READ && !op_r[BANK_BIT] && ext_set_i && op_r[7:0] <= INDEX_MAX_ADDR)
        |=> (addr_r == ($past(index_base_i) + {4'h0, op_r[7:0]})))
        else $error("indexed address wrong");
    // Instruction completes four clocks after acceptance
    four_phase_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (phase_r == SBD_DECODE && instr_valid_i) |-> ##4 done_o) else $error("cycle length wrong");
    // Borrow instruction reads the file register
    borrow_read_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (phase_r == SBD_READ && kind_r == 2'd3) |=> file_rd_o) else $error("no operand read");
endmodule : sbd_core

/* File: sbd_regfile_model.sv */
// Behavioural data memory that stands behind the subtract datapath.
// Assumes reads are strobed by file_rd_i and writes by file_wr_i on the rising edge.
module sbd_regfile_model (
    input  wire logic        mclk_i,
    input  wire logic [11:0] file_addr_i,
    input  wire logic        file_rd_i,
    input  wire logic [7:0]  file_wdata_i,
    input  wire logic        file_wr_i,
    output logic      [7:0]  file_rdata_o
);
    logic [7:0] mem [0:4095];
    logic [7:0] held_r = 8'h00;
    logic       hold_r = 1'b0;

    // Writes land on the edge; read data is kept one cycle past the strobe
    always @(posedge mclk_i) begin
        hold_r <= file_rd_i;
        if (file_rd_i) held_r <= mem[file_addr_i];
        if (file_wr_i) mem[file_addr_i] <= file_wdata_i;
    end

    // After the one held cycle the bus shows the inverse, never a stale match
    always_comb file_rdata_o = file_rd_i ? mem[file_addr_i] : (hold_r ? held_r : ~held_r);
endmodule : sbd_regfile_model

/* File: test_sbd_core.sv */
// Self-checking bench for the subtract datapath and its data memory model.
// Assumes sbd_core and sbd_regfile_model; inputs change on the rising edge only.
module test_sbd_core;
    import sbd_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk_i, rst_i, instr_valid_i, carry_i, ext_set_i, file_rd_o, file_wr_o;
    logic work_wr_o, flags_wr_o, busy_o, done_o;
    logic [15:0] instr_i;
    logic [7:0]  work_i, file_rdata_i, file_wdata_o, work_o, got_work, got_fdata;
    logic [3:0]  bank_select_register_i;
    logic [11:0] index_base_i, file_addr_o, got_addr;
    logic [4:0]  flags_o, got_flags;
    logic        got_rd, got_done, got_wwr, got_fwr, got_fl_wr;
    logic        got_busy_bad, got_busy_end;
    int          err_total = 0;
    int          num_checks = 0;

    sbd_core u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
        .instr_i(instr_i), .carry_i(carry_i), .work_i(work_i),
        .bank_select_register_i(bank_select_register_i), .ext_set_i(ext_set_i),
        .index_base_i(index_base_i), .file_rdata_i(file_rdata_i), .file_addr_o(file_addr_o),
        .file_rd_o(file_rd_o), .file_wdata_o(file_wdata_o), .file_wr_o(file_wr_o),
        .work_o(work_o), .work_wr_o(work_wr_o), .flags_o(flags_o), .flags_wr_o(flags_wr_o),
        .busy_o(busy_o), .done_o(done_o));

    sbd_regfile_model u_mem (.mclk_i(mclk_i), .file_addr_i(file_addr_o), .file_rd_i(file_rd_o),
        .file_wdata_i(file_wdata_o), .file_wr_i(file_wr_o), .file_rdata_o(file_rdata_i));

    // 50 MHz clock
    initial begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end

    // Compare tasks, one per result kind
    task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: data %h expected %h", $time, got, exp);
        end
    endtask : chk_data

    task automatic chk_addr(input logic [11:0] got, input logic [11:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: address %h expected %h", $time, got, exp);
        end
    endtask : chk_addr

    task automatic chk_flag(input logic [4:0] got, input logic [4:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: flags %b expected %b", $time, got, exp);
        end
    endtask : chk_flag

    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // Issue one instruction and capture the read strobe and the result pulses
    task automatic run_op(input logic [15:0] ins, input logic c, input logic [7:0] w);
        got_rd = 1'b0;
        got_done = 1'b0;
        got_busy_bad = 1'b0;
        got_busy_end = 1'b1;
        @(posedge mclk_i);
        instr_valid_i <= 1'b1;
        instr_i <= ins;
        carry_i <= c;
        work_i <= w;
        @(posedge mclk_i);
        instr_valid_i <= 1'b0;
        for (int n = 0; n < 8 && !got_done; n++) begin
            @(negedge mclk_i);
            if (file_rd_o === 1'b1) begin
                got_rd = 1'b1;
                got_addr = file_addr_o;
            end
            if ((done_o !== 1'b1) && (busy_o !== 1'b1)) begin
                got_busy_bad = 1'b1;
            end
            if (done_o === 1'b1) begin
                got_done = 1'b1;
                got_busy_end = busy_o;
                {got_wwr, got_work, got_fwr, got_fdata, got_fl_wr, got_flags} =
                    {work_wr_o, work_o, file_wr_o, file_wdata_o, flags_wr_o, flags_o};
            end
        end
        if (!got_done) begin
            err_total++;
            $display("CHECK FAILED at %0t: no completion pulse", $time);
            tally_and_finish();
        end
    endtask : run_op

    // Run one subtract and judge destination, address and flags from its operands
    task automatic do_op(input logic [15:0] ins, input logic c, input logic [7:0] w,
                         input logic [7:0] fv, input logic [11:0] addr);
        logic lit, to_file, b;
        logic [7:0] m, s, d;
        logic [8:0] t;
        lit = (ins[15:8] == LIT_SUB_CODE);
        to_file = !lit && ins[DEST_BIT];
        m = lit ? ins[7:0] : ((ins[15:10] == FSUBW_CODE) ? fv : w);
        s = (!lit && ins[15:10] == FSUBB_CODE) ? fv : w;
        b = (!lit && ins[15:10] == FSUBB_CODE) ? ~c : 1'b0;
        if (!lit) u_mem.mem[addr] = fv;
        run_op(ins, c, w);
        t = {1'b0, m} - {1'b0, s} - {8'h00, b};
        d = t[7:0];
        chk_flag({4'h0, got_rd}, {4'h0, !lit});
        if (!lit) chk_addr(got_addr, addr);
        chk_flag({3'h0, got_wwr, got_fwr}, {3'h0, !to_file, to_file});
        chk_data(to_file ? got_fdata : got_work, d);
        chk_flag({4'h0, got_fl_wr}, 5'h01);
        chk_flag(got_flags, {d[7], (m[7] ^ s[7]) & (m[7] ^ d[7]), d == 8'h00,
            {1'b0, m[3:0]} >= ({1'b0, s[3:0]} + {4'h0, b}), ~t[8]});
        chk_flag({3'h0, got_busy_bad, got_busy_end}, 5'h00);
        @(negedge mclk_i);
        if (to_file) chk_data(u_mem.mem[addr], d);
    endtask : do_op

    task automatic set_mode(input logic [3:0] bank, input logic ext, input logic [11:0] base);
        @(posedge mclk_i);
        bank_select_register_i <= bank;
        ext_set_i <= ext;
        index_base_i <= base;
    endtask : set_mode

    // Scenarios
    task automatic t_literal;
        do_op(16'h0802, 1'b0, 8'h01, 8'h00, 12'h000);
        do_op(16'h0802, 1'b1, 8'h03, 8'h00, 12'h000);
        do_op(16'h0880, 1'b0, 8'h01, 8'h00, 12'h000);
        $display("t_literal done");
    endtask : t_literal

    task automatic t_file_sub;
        set_mode(4'h0, 1'b0, 12'h000);
        do_op(16'h5E20, 1'b0, 8'h02, 8'h03, 12'h020);
        do_op(16'h5C20, 1'b0, 8'h02, 8'h02, 12'h020);
        do_op(16'h5E21, 1'b1, 8'h02, 8'h01, 12'h021);
        do_op(16'h5620, 1'b1, 8'h02, 8'h03, 12'h020);
        do_op(16'h5420, 1'b1, 8'h05, 8'h02, 12'h020);
        do_op(16'h5620, 1'b0, 8'h02, 8'h01, 12'h020);
        $display("t_file_sub done");
    endtask : t_file_sub

    task automatic t_banks;
        set_mode(4'h5, 1'b0, 12'h300);
        do_op(16'h5D90, 1'b0, 8'h10, 8'h40, 12'h590);
        do_op(16'h5C90, 1'b0, 8'h10, 8'h40, 12'hF90);
        do_op(16'h5C7F, 1'b0, 8'h10, 8'h40, 12'h07F);
        do_op(16'h5C5F, 1'b0, 8'h10, 8'h40, 12'h05F);
        set_mode(4'h5, 1'b1, 12'h300);
        do_op(16'h5C5F, 1'b0, 8'h10, 8'h40, 12'h35F);
        do_op(16'h5C60, 1'b0, 8'h10, 8'h40, 12'h060);
        do_op(16'h5D10, 1'b0, 8'h10, 8'h40, 12'h510);
        $display("t_banks done");
    endtask : t_banks

    task automatic t_unknown;
        logic [4:0] prev;
        prev = flags_o;
        run_op(16'hFFFF, 1'b1, 8'h33);
        chk_flag({2'h0, got_wwr, got_fwr, got_fl_wr}, 5'h00);
        chk_flag({4'h0, got_rd}, 5'h00);
        chk_flag(got_flags, prev);
        $display("t_unknown done");
    endtask : t_unknown

    // Reset, then the scenarios in turn
    initial begin
        {rst_i, instr_valid_i, instr_i, carry_i, work_i} = {1'b1, 1'b0, 16'h0000, 1'b0, 8'h00};
        {bank_select_register_i, ext_set_i, index_base_i} = {4'h0, 1'b0, 12'h000};
        repeat (20) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(negedge mclk_i);
        chk_flag({3'h0, busy_o, done_o}, 5'h00);
        t_literal();
        t_file_sub();
        t_banks();
        t_unknown();
        tally_and_finish();
    end
endmodule : test_sbd_core
